// ==== logic/rlp_pkg.sv ====
// Shared constants and types of the RGB lighting controller
package rlp_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int BAUD_BPS = 9600;
	localparam int BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
	localparam int PWM_TICK_NS = 1000;
	localparam int PWM_TICK_CYCLES = PWM_TICK_NS / CLK_PERIOD_NS;
	localparam int US_PER_S = 1_000_000;
	localparam int FREQ_LOW_HZ = 30;
	localparam int FREQ_MID_HZ = 120;
	localparam int FREQ_HIGH_HZ = 600;
	localparam logic [15:0] TOP_LOW = 16'(US_PER_S / FREQ_LOW_HZ - 1);
	localparam logic [15:0] TOP_MID = 16'(US_PER_S / FREQ_MID_HZ - 1);
	localparam logic [15:0] TOP_HIGH = 16'(US_PER_S / FREQ_HIGH_HZ - 1);
	localparam int DEBOUNCE_MS = 5;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int DEMO_TICK_MS = 10;
	localparam int DEMO_TICK_CYCLES = DEMO_TICK_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam logic [15:0] BRIGHT_STEP = 16'h0100;
	localparam logic [7:0] FADE_STEP = 8'h08;
	localparam logic [7:0] FADE_TOP = 8'hf8;
	localparam logic [15:0] WHITE_GREEN_INIT = 16'h1000;
	localparam logic [8:0] WARM_RED = 9'h140;
	localparam logic [8:0] WARM_BLUE = 9'h0a0;
	localparam logic [8:0] COOL_RED = 9'h0e0;
	localparam logic [8:0] COOL_BLUE = 9'h120;
	localparam logic [47:0] PRESET [4] = '{48'h2000_0000_0000,
		48'h0000_2000_0000, 48'h0000_0000_2000, 48'h1800_1000_0400};
	typedef enum logic [1:0] {FREQ_30, FREQ_120, FREQ_600} rlp_freq_t;
	localparam int BTN_COLOR = 0;
	localparam int BTN_WHITE = 1;
	localparam int BTN_UP = 2;
	localparam int BTN_DOWN = 3;
	localparam int BTN_DEMO = 4;
	localparam int NUM_BTN = 5;
	localparam logic [7:0] CH_DEMO = 8'h64;
	localparam logic [7:0] CH_COLOR = 8'h63;
	localparam logic [7:0] CH_WB = 8'h77;
	localparam logic [7:0] CH_TEMP = 8'h74;
	localparam logic [7:0] CH_UP = 8'h2b;
	localparam logic [7:0] CH_DOWN = 8'h2d;
	localparam logic [7:0] CH_RED = 8'h72;
	localparam logic [7:0] CH_GREEN = 8'h67;
	localparam logic [7:0] CH_BLUE = 8'h62;
	localparam logic [7:0] CH_FREQ = 8'h66;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_M = 8'h4d;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [119:0] MENU_TXT = "KEYS:dcwt+-rgbf";
	localparam logic [23:0] TXT_LOW = "030";
	localparam logic [23:0] TXT_MID = "120";
	localparam logic [23:0] TXT_HIGH = "600";
	localparam logic [5:0] REP_START = 6'h11;
	localparam logic [5:0] TXT_LAST = 6'h26;
	localparam int TXT_BITS = 312;
endpackage : rlp_pkg

// ==== logic/rlp_debounce.sv ====
// Push-button debouncer: output follows input after it stays put
`timescale 1ns/100ps
module rlp_debounce #(
	parameter int P_CYCLES = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_raw,
	output logic o_level
);
	localparam int CW = $clog2(P_CYCLES + 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || i_raw == o_level) begin
			cnt <= '0;
		end else if (cnt == CW'(P_CYCLES - 1)) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_level <= 1'b0;
		end else if (i_raw != o_level && cnt == CW'(P_CYCLES - 1)) begin
			o_level <= i_raw;
		end
	end
endmodule : rlp_debounce

// ==== logic/rlp_fifo2.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module rlp_fifo2 #(
	parameter int W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	logic [W-1:0] slot1;
	logic [1:0] count;
	logic push;
	logic pop;

	assign o_ready = (count != 2'h2);
	assign o_valid = (count != 2'h0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			count <= 2'h0;
			o_data <= '0;
			slot1 <= '0;
		end else begin
			count <= count + {1'b0, push} - {1'b0, pop};
			if (push && !pop) begin
				if (count == 2'h0) begin
					o_data <= i_data;
				end else begin
					slot1 <= i_data;
				end
			end else if (pop && !push) begin
				o_data <= slot1;
			end else if (pop && push) begin
				if (count == 2'h1) begin
					o_data <= i_data;
				end else begin
					o_data <= slot1;
					slot1 <= i_data;
				end
			end
		end
	end
endmodule : rlp_fifo2

// ==== logic/rlp_lighting_ctrl.sv ====
// RGB lighting controller: PWM, host commands, buttons, demo
`timescale 1ns/100ps
//
// Summary of operation
// - Button free at power-up: host mode
// - Button held at power-up: standalone mode
// - Three edge-aligned PWMs from one timer
// - New duty takes effect next period
// - Host mode sends menu then settings
// - Auto white keeps ratio; steps scale all
// - Auto white derives red, blue from green
// - Hex input capitals; report four digits
// - Decode single-key host commands
// - Demo button toggles fading demo sequence
// - Colour button release: next preset, indicator
// - White button: auto white, swap temperature
// - Colour button leaves auto white
// - Two buttons step brightness opposite ways
// - Chord sequence advances PWM frequency
// - Frequency cycles 30, 120, 600 Hz
// - Frequency change keeps compare values
// - Frequency chord ignored during demo
// - Leaving demo restores 120 Hz
// - Separate tick timer paces demo
// - Serial link 9600 baud, 8N1
module rlp_lighting_ctrl import rlp_pkg::*; #(
	parameter int P_BIT_CYCLES = BIT_CYCLES,
	parameter int P_DEBOUNCE_CYCLES = DEBOUNCE_CYCLES,
	parameter int P_DEMO_TICK_CYCLES = DEMO_TICK_CYCLES,
	parameter logic [15:0] P_TOP_LOW = TOP_LOW,
	parameter logic [15:0] P_TOP_MID = TOP_MID,
	parameter logic [15:0] P_TOP_HIGH = TOP_HIGH
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_color_mode_button,
	input wire logic i_white_button,
	input wire logic i_bright_a_button,
	input wire logic i_bright_b_button,
	input wire logic i_demo_button,
	input wire logic i_serial_rx,
	output logic o_serial_tx,
	output logic o_pwm_red,
	output logic o_pwm_green,
	output logic o_pwm_blue,
	output logic o_color_indicator,
	output logic o_white_indicator,
	output logic o_standalone
);
	function automatic logic [15:0] scale_sat(logic [15:0] x, logic [8:0] k);
		logic [24:0] p;
		p = x * k;
		scale_sat = p[24] ? 16'hffff : p[23:8];
	endfunction : scale_sat

	function automatic logic [7:0] hex_ch(logic [3:0] n);
		hex_ch = (n < 4'ha) ? CH_0 + {4'h0, n} : CH_A + {4'h0, n - 4'ha};
	endfunction : hex_ch

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	// ----------------------------------------
	// Mode selection at power-up
	// ----------------------------------------
	logic mode_done;
	logic color_mask;
	logic sa;
	logic host;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			mode_done <= 1'b0;
			o_standalone <= 1'b0;
		end else if (!mode_done) begin
			mode_done <= 1'b1;
			o_standalone <= i_color_mode_button;
		end
	end
	assign sa = mode_done && o_standalone;
	assign host = mode_done && !o_standalone;

	// ----------------------------------------
	// Buttons
	// ----------------------------------------
	logic [NUM_BTN-1:0] raw;
	logic [NUM_BTN-1:0] db;
	logic [NUM_BTN-1:0] db_q;
	logic [NUM_BTN-1:0] press;
	logic [NUM_BTN-1:0] rel;
	logic chord;
	logic freq_armed;
	assign raw = {i_demo_button, i_bright_b_button, i_bright_a_button,
		i_white_button, i_color_mode_button};
	for (genvar k = 0; k < NUM_BTN; k++) begin : g_deb
		rlp_debounce #(.P_CYCLES(P_DEBOUNCE_CYCLES)) u_deb (
			.i_ref_clk(i_ref_clk),
			.i_sys_rst(i_sys_rst),
			.i_raw(raw[k]),
			.o_level(db[k])
		);
	end
	assign press = db & ~db_q;
	assign rel = ~db & db_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			db_q <= '0;
			chord <= 1'b0;
			freq_armed <= 1'b0;
			color_mask <= 1'b1;
		end else begin
			db_q <= db;
			// Hold-to-boot press must not count as a colour step
			if (rel[BTN_COLOR] || (!mode_done && !i_color_mode_button)) begin
				color_mask <= 1'b0;
			end
			if (rel[BTN_COLOR]) begin
				chord <= 1'b0;
				freq_armed <= 1'b0;
			end else if (db[BTN_COLOR] && press[BTN_WHITE]) begin
				chord <= 1'b1;
			end else if (db[BTN_COLOR] && rel[BTN_WHITE] && chord) begin
				freq_armed <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Serial receiver
	// ----------------------------------------
	logic rx_busy;
	logic [15:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_sh;
	logic rx_valid;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			rx_busy <= 1'b0;
			rx_cnt <= '0;
			rx_bit <= '0;
			rx_sh <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!i_serial_rx) begin
					rx_busy <= 1'b1;
					rx_bit <= 4'h0;
					rx_cnt <= 16'(P_BIT_CYCLES / 2);
				end
			end else if (rx_cnt != 16'h0) begin
				rx_cnt <= rx_cnt - 1'b1;
			end else begin
				rx_cnt <= 16'(P_BIT_CYCLES - 1);
				rx_bit <= rx_bit + 1'b1;
				if (rx_bit == 4'h0 && i_serial_rx) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == 4'h9) begin
					rx_busy <= 1'b0;
					rx_valid <= i_serial_rx;
				end else if (rx_bit != 4'h0) begin
					rx_sh <= {i_serial_rx, rx_sh[7:1]};
				end
			end
		end
	end

	// ----------------------------------------
	// Host command decoder
	// ----------------------------------------
	typedef enum {HS_CMD, HS_HEX} rlp_hs_t;
	rlp_hs_t hs;
	logic [1:0] hex_chan;
	logic [1:0] hex_n;
	logic [15:0] hex_acc;
	logic is_hex;
	logic [3:0] nib;
	logic ev_load;
	logic rep_pend;
	assign is_hex = (rx_sh >= CH_0 && rx_sh <= CH_9)
		|| (rx_sh >= CH_A && rx_sh <= CH_F);
	assign nib = (rx_sh <= CH_9) ? rx_sh[3:0] : 4'(rx_sh - CH_A + 8'h0a);
	assign ev_load = host && rx_valid && hs == HS_HEX && is_hex
		&& hex_n == 2'h3;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			hs <= HS_CMD;
			hex_chan <= 2'h0;
			hex_n <= 2'h0;
			hex_acc <= '0;
		end else if (host && rx_valid) begin
			unique case (hs)
				HS_CMD: begin
					hex_n <= 2'h0;
					if (rx_sh == CH_RED || rx_sh == CH_GREEN
						|| rx_sh == CH_BLUE) begin
						hs <= HS_HEX;
						hex_chan <= (rx_sh == CH_RED) ? 2'h0
							: (rx_sh == CH_GREEN) ? 2'h1 : 2'h2;
					end
				end
				HS_HEX: begin
					hex_acc <= {hex_acc[11:0], nib};
					hex_n <= hex_n + 1'b1;
					if (!is_hex || hex_n == 2'h3) begin
						hs <= HS_CMD;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Event merge
	// ----------------------------------------
	logic ev_demo;
	logic ev_color;
	logic ev_white;
	logic ev_wb;
	logic ev_temp;
	logic ev_up;
	logic ev_down;
	logic ev_freq;
	logic cmd;
	assign cmd = host && rx_valid && hs == HS_CMD;
	assign ev_demo = (sa && press[BTN_DEMO]) || (cmd && rx_sh == CH_DEMO);
	assign ev_color = (sa && rel[BTN_COLOR] && !freq_armed && !color_mask)
		|| (cmd && rx_sh == CH_COLOR);
	assign ev_white = sa && press[BTN_WHITE] && !db[BTN_COLOR];
	assign ev_wb = cmd && rx_sh == CH_WB;
	assign ev_temp = cmd && rx_sh == CH_TEMP;
	assign ev_up = (sa && press[BTN_UP]) || (cmd && rx_sh == CH_UP);
	assign ev_down = (sa && press[BTN_DOWN]) || (cmd && rx_sh == CH_DOWN);
	assign ev_freq = (sa && rel[BTN_COLOR] && freq_armed)
		|| (cmd && rx_sh == CH_FREQ);

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [15:0] duty_r;
	logic [15:0] duty_g;
	logic [15:0] duty_b;
	logic [1:0] preset_idx;
	logic [1:0] next_preset;
	logic wb_auto;
	logic temp_sel;
	logic demo_on;
	rlp_freq_t freq;
	rlp_freq_t next_freq;
	assign next_preset = preset_idx + 1'b1;
	assign next_freq = (freq == FREQ_30) ? FREQ_120
		: (freq == FREQ_120) ? FREQ_600 : FREQ_30;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			demo_on <= 1'b0;
			freq <= FREQ_120;
		end else if (ev_demo) begin
			demo_on <= !demo_on;
			if (demo_on) begin
				freq <= FREQ_120;
			end
		end else if (ev_freq && !demo_on) begin
			freq <= next_freq;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			{duty_r, duty_g, duty_b} <= '0;
			preset_idx <= 2'h0;
			wb_auto <= 1'b0;
			temp_sel <= 1'b0;
			o_color_indicator <= 1'b0;
			o_white_indicator <= 1'b0;
		end else if (ev_color) begin
			preset_idx <= next_preset;
			{duty_r, duty_g, duty_b} <= PRESET[next_preset];
			wb_auto <= 1'b0;
			o_color_indicator <= 1'b1;
			o_white_indicator <= 1'b0;
		end else if (ev_white || ev_wb || ev_temp) begin
			if ((ev_white || ev_temp) && wb_auto) begin
				temp_sel <= !temp_sel;
			end else if (ev_white || (ev_wb && !wb_auto)) begin
				wb_auto <= 1'b1;
				duty_g <= WHITE_GREEN_INIT;
			end else if (ev_wb) begin
				wb_auto <= 1'b0;
			end
			if (ev_white) begin
				o_white_indicator <= 1'b1;
				o_color_indicator <= 1'b0;
			end
		end else if (ev_up) begin
			duty_g <= (duty_g > ~BRIGHT_STEP) ? 16'hffff : duty_g + BRIGHT_STEP;
			if (!wb_auto) begin
				duty_r <= (duty_r > ~BRIGHT_STEP) ? 16'hffff
					: duty_r + BRIGHT_STEP;
				duty_b <= (duty_b > ~BRIGHT_STEP) ? 16'hffff
					: duty_b + BRIGHT_STEP;
			end
		end else if (ev_down) begin
			duty_g <= (duty_g < BRIGHT_STEP) ? 16'h0 : duty_g - BRIGHT_STEP;
			if (!wb_auto) begin
				duty_r <= (duty_r < BRIGHT_STEP) ? 16'h0 : duty_r - BRIGHT_STEP;
				duty_b <= (duty_b < BRIGHT_STEP) ? 16'h0 : duty_b - BRIGHT_STEP;
			end
		end else if (ev_load) begin
			// In auto white only green is accepted; the rest follows it
			if (hex_chan == 2'h1) begin
				duty_g <= {hex_acc[11:0], nib};
			end else if (!wb_auto && hex_chan == 2'h0) begin
				duty_r <= {hex_acc[11:0], nib};
			end else if (!wb_auto) begin
				duty_b <= {hex_acc[11:0], nib};
			end
		end
	end

	// ----------------------------------------
	// Demo sequencer on its own tick timer
	// ----------------------------------------
	logic [20:0] demo_cnt;
	logic demo_tick;
	logic [7:0] level;
	logic fade_down;
	logic [1:0] demo_idx;
	assign demo_tick = demo_cnt == 21'(P_DEMO_TICK_CYCLES - 1);
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !demo_on) begin
			demo_cnt <= '0;
			level <= 8'h0;
			fade_down <= 1'b0;
			demo_idx <= 2'h0;
		end else begin
			demo_cnt <= demo_tick ? 21'h0 : demo_cnt + 1'b1;
			if (demo_tick && !fade_down) begin
				level <= level + FADE_STEP;
				fade_down <= (level + FADE_STEP >= FADE_TOP);
			end else if (demo_tick) begin
				level <= level - FADE_STEP;
				if (level == FADE_STEP) begin
					fade_down <= 1'b0;
					demo_idx <= demo_idx + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Effective values and PWM
	// ----------------------------------------
	logic [15:0] eff_r;
	logic [15:0] eff_g;
	logic [15:0] eff_b;
	logic [15:0] out_r;
	logic [15:0] out_g;
	logic [15:0] out_b;
	logic [47:0] dc;
	assign dc = PRESET[demo_idx];
	assign eff_g = duty_g;
	assign eff_r = wb_auto ? scale_sat(duty_g, temp_sel ? COOL_RED : WARM_RED)
		: duty_r;
	assign eff_b = wb_auto ? scale_sat(duty_g, temp_sel ? COOL_BLUE : WARM_BLUE)
		: duty_b;
	assign out_r = demo_on ? scale_sat(dc[47:32], {1'b0, level}) : eff_r;
	assign out_g = demo_on ? scale_sat(dc[31:16], {1'b0, level}) : eff_g;
	assign out_b = demo_on ? scale_sat(dc[15:0], {1'b0, level}) : eff_b;

	logic [6:0] presc;
	logic us_tick;
	logic [15:0] pwm_cnt;
	logic [15:0] top;
	logic period_end;
	logic [15:0] sh_r;
	logic [15:0] sh_g;
	logic [15:0] sh_b;
	assign us_tick = presc == 7'(PWM_TICK_CYCLES - 1);
	assign top = (freq == FREQ_30) ? P_TOP_LOW
		: (freq == FREQ_120) ? P_TOP_MID : P_TOP_HIGH;
	// A shorter new period must not let the counter run past its top
	assign period_end = us_tick && pwm_cnt >= top;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			presc <= '0;
			pwm_cnt <= '0;
			{sh_r, sh_g, sh_b} <= '0;
			{o_pwm_red, o_pwm_green, o_pwm_blue} <= 3'h0;
		end else begin
			presc <= us_tick ? 7'h0 : presc + 1'b1;
			if (period_end) begin
				pwm_cnt <= 16'h0;
				{sh_r, sh_g, sh_b} <= {out_r, out_g, out_b};
			end else if (us_tick) begin
				pwm_cnt <= pwm_cnt + 1'b1;
			end
			o_pwm_red <= pwm_cnt < sh_r;
			o_pwm_green <= pwm_cnt < sh_g;
			o_pwm_blue <= pwm_cnt < sh_b;
		end
	end

	// ----------------------------------------
	// Menu and report text, buffer, transmitter
	// ----------------------------------------
	logic gen_started;
	logic gen_busy;
	logic [5:0] gen_idx;
	logic [TXT_BITS-1:0] txt;
	logic [7:0] gen_ch;
	logic f_ready;
	logic f_valid;
	logic [7:0] f_data;
	logic tx_busy;
	logic [9:0] tx_sh;
	logic [3:0] tx_bit;
	logic [15:0] tx_cnt;
	assign txt = {MENU_TXT, CH_CR, CH_LF, wb_auto ? CH_A : CH_M, CH_SP,
		(freq == FREQ_30) ? TXT_LOW : (freq == FREQ_120) ? TXT_MID : TXT_HIGH,
		CH_SP, hex_ch(eff_r[15:12]), hex_ch(eff_r[11:8]), hex_ch(eff_r[7:4]),
		hex_ch(eff_r[3:0]), CH_SP, hex_ch(eff_g[15:12]), hex_ch(eff_g[11:8]),
		hex_ch(eff_g[7:4]), hex_ch(eff_g[3:0]), CH_SP, hex_ch(eff_b[15:12]),
		hex_ch(eff_b[11:8]), hex_ch(eff_b[7:4]), hex_ch(eff_b[3:0]),
		CH_CR, CH_LF};
	assign gen_ch = txt[9'(TXT_BITS - 8) - {gen_idx, 3'h0} +: 8];

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			gen_started <= 1'b0;
			gen_busy <= 1'b0;
			gen_idx <= '0;
			rep_pend <= 1'b0;
		end else begin
			if (cmd || ev_load) begin
				rep_pend <= 1'b1;
			end
			if (host && !gen_started) begin
				gen_started <= 1'b1;
				gen_busy <= 1'b1;
				gen_idx <= 6'h0;
			end else if (!gen_busy && rep_pend) begin
				rep_pend <= cmd || ev_load;
				gen_busy <= 1'b1;
				gen_idx <= REP_START;
			end else if (gen_busy && f_ready) begin
				gen_idx <= gen_idx + 1'b1;
				gen_busy <= gen_idx != TXT_LAST;
			end
		end
	end

	rlp_fifo2 #(.W(8)) u_txbuf (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_valid(gen_busy),
		.o_ready(f_ready),
		.i_data(gen_ch),
		.o_valid(f_valid),
		.i_ready(!tx_busy),
		.o_data(f_data)
	);

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			tx_busy <= 1'b0;
			tx_sh <= '1;
			tx_bit <= '0;
			tx_cnt <= '0;
			o_serial_tx <= 1'b1;
		end else if (!tx_busy) begin
			if (f_valid) begin
				tx_busy <= 1'b1;
				tx_sh <= {1'b1, f_data, 1'b0};
				tx_bit <= 4'h0;
				tx_cnt <= 16'h0;
			end
		end else if (tx_cnt == 16'h0) begin
			o_serial_tx <= tx_sh[0];
			tx_sh <= {1'b1, tx_sh[9:1]};
			tx_cnt <= 16'(P_BIT_CYCLES - 1);
			tx_bit <= tx_bit + 1'b1;
			tx_busy <= tx_bit != 4'ha;
		end else begin
			tx_cnt <= tx_cnt - 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_mode_hold: assert property (
		mode_done |=> $stable(o_standalone))
		else $error("operating mode changed after power-up");
	a_pwm_dark: assert property (
		sh_r == 16'h0 && $past(sh_r) == 16'h0 |=> !o_pwm_red)
		else $error("red output high with zero duty");
	a_duty_hold: assert property (
		!period_end |=> $stable(sh_g))
		else $error("duty changed inside a period");
	a_freq_duty: assert property (
		ev_freq && !ev_load |=> $stable(duty_r) && $stable(duty_g))
		else $error("frequency change altered compare values");
	a_demo_nofreq: assert property (
		demo_on && !ev_demo |=> $stable(freq))
		else $error("frequency moved during demo");
	a_demo_exit: assert property (
		demo_on && ev_demo |=> freq == FREQ_120)
		else $error("demo exit did not restore default frequency");
	a_freq_order: assert property (
		!demo_on && ev_freq && !ev_demo |=> freq == $past(next_freq))
		else $error("frequency step out of order");
	a_white_ind: assert property (
		ev_white |=> o_white_indicator && !o_color_indicator && wb_auto)
		else $error("white press did not show auto white");
	a_color_ind: assert property (
		ev_color |=> o_color_indicator && !o_white_indicator && !wb_auto)
		else $error("colour step did not show colour indicator");
	// Below this green no warm product saturates: plain arithmetic holds
	a_white_ratio: assert property (
		wb_auto && !temp_sel && duty_g < WHITE_GREEN_INIT
		|-> 32'(eff_r) == (32'(duty_g) * 32'(WARM_RED)) >> 8)
		else $error("red does not follow green in auto white");
	c_freq_step: cover property (sa && ev_freq ##1 freq == FREQ_600);
	c_demo_run: cover property (demo_on && demo_tick && fade_down);
	c_hex_load: cover property (ev_load && hex_chan == 2'h1 && wb_auto);
	c_menu_out: cover property (gen_busy && gen_idx == TXT_LAST && f_ready);
endmodule : rlp_lighting_ctrl

// ==== bench/rlp_host_model.sv ====
// Host terminal model: serial sender and byte collector
`timescale 1ns/100ps
module rlp_host_model #(
	parameter int P_BIT = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_tx,
	output logic o_rx
);
	logic [7:0] rx_q [$];
	initial o_rx = 1'b1;
	// 8N1 frame, idle high, no flow control
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_rx <= f[i];
			repeat (P_BIT) @(posedge i_ref_clk);
		end
	endtask : send
	// Four digits, MSB first, capitals only
	task automatic send_hex(input logic [15:0] v);
		logic [7:0] d;
		for (int i = 3; i >= 0; i--) begin
			d = {4'h0, v[i*4+:4]};
			send(d < 8'h0a ? d + 8'h30 : d + 8'h37);
		end
	endtask : send_hex
	// Mid-bit sampling keeps clear of edge jitter
	always begin : rx_loop
		logic [7:0] b;
		@(negedge i_tx);
		repeat (P_BIT / 2) @(posedge i_ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (P_BIT) @(posedge i_ref_clk);
			b[i] = i_tx;
		end
		repeat (P_BIT) @(posedge i_ref_clk);
		rx_q.push_back(b);
	end
endmodule : rlp_host_model

// ==== bench/tb_rgb_led_pwm_lighting_control.sv ====
// Testbench of the RGB lighting controller
`timescale 1ns/100ps
module tb_rgb_led_pwm_lighting_control import rlp_pkg::*;;
	logic i_ref_clk, i_sys_rst, rx, tx, r, g, b, ci, wi, sa;
	logic [NUM_BTN-1:0] btn;
	int n_fail, n_tests;
	// Slow 30 Hz top keeps its long default: no scenario steps to it
	rlp_lighting_ctrl #(.P_BIT_CYCLES(16), .P_DEBOUNCE_CYCLES(4),
		.P_DEMO_TICK_CYCLES(20), .P_TOP_MID(16'h0007),
		.P_TOP_HIGH(16'h0003)) DUT (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_color_mode_button(btn[BTN_COLOR]),
		.i_white_button(btn[BTN_WHITE]),
		.i_bright_a_button(btn[BTN_UP]),
		.i_bright_b_button(btn[BTN_DOWN]),
		.i_demo_button(btn[BTN_DEMO]), .i_serial_rx(rx),
		.o_serial_tx(tx), .o_pwm_red(r), .o_pwm_green(g),
		.o_pwm_blue(b), .o_color_indicator(ci),
		.o_white_indicator(wi), .o_standalone(sa));
	// Model's default bit time equals the shortened one above
	rlp_host_model host (.i_ref_clk(i_ref_clk),
		.i_tx(tx), .o_rx(rx));
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Reported four-digit value; off counts back from the line end
	task automatic chk_hex(input int off, input logic [15:0] exp);
		logic [15:0] v;
		logic [7:0] c;
		int n;
		n = host.rx_q.size();
		v = '0;
		for (int i = 0; i < 4; i++) begin
			c = host.rx_q[n - off + i];
			v = {v[11:0], c[3:0] + (c[6] ? 4'h9 : 4'h0)};
		end
		chk(v, exp);
	endtask : chk_hex
	task automatic boot(input logic hold);
		btn <= NUM_BTN'(hold) << BTN_COLOR;
		i_sys_rst <= 1'b1;
		repeat (8) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
		btn[BTN_COLOR] <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
	endtask : boot
	task automatic press(input int k);
		btn[k] <= 1'b1;
		repeat (20) @(posedge i_ref_clk);
		btn[k] <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
	endtask : press
	// Line quiet for 200 cycles: report finished
	task automatic quiet();
		int q;
		q = 0;
		while (q < 200) begin
			@(posedge i_ref_clk);
			q = tx ? q + 1 : 0;
		end
	endtask : quiet
	// Two whole periods of the mid setting, 1000 cycles each
	task automatic duty(output int nr, output int ng);
		nr = 0;
		ng = 0;
		repeat (2000) begin
			@(posedge i_ref_clk);
			nr += r;
			ng += g;
		end
	endtask : duty
	task automatic summarize();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int nr, ng, n;
		n_fail = 0;
		n_tests = 0;
		boot(1'b0);
		chk(16'(sa), 16'h0);
		quiet();
		n = host.rx_q.size();
		chk(16'(n), 16'd39);
		chk(16'(host.rx_q[0]), 16'h4b);
		chk(16'(host.rx_q[19]), 16'h31);
		host.send(CH_RED);
		host.send_hex(16'h000b);
		host.send(CH_RED);
		host.send_hex(16'h0004);
		quiet();
		n = host.rx_q.size();
		chk(16'(host.rx_q[n - 13]), 16'h34);
		duty(nr, ng);
		chk(16'(nr), 16'd1000);
		chk(16'(ng), 16'd0);
		host.send(CH_FREQ);
		quiet();
		n = host.rx_q.size();
		chk(16'(host.rx_q[n - 20]), 16'h36);
		duty(nr, ng);
		chk(16'(nr), 16'd2000);
		host.send(CH_WB);
		host.send(CH_GREEN);
		host.send_hex(16'h0100);
		quiet();
		chk_hex(16, 16'(WARM_RED));
		chk_hex(6, 16'(WARM_BLUE));
		host.send(CH_UP);
		host.send(CH_TEMP);
		quiet();
		chk_hex(11, 16'h0100 + BRIGHT_STEP);
		chk_hex(16, 16'(COOL_RED) << 1);
		chk_hex(6, 16'(COOL_BLUE) << 1);
		host.send(CH_DEMO);
		host.send(CH_FREQ);
		quiet();
		n = host.rx_q.size();
		chk(16'(host.rx_q[n - 20]), 16'h36);
		host.send(CH_DEMO);
		quiet();
		n = host.rx_q.size();
		chk(16'(host.rx_q[n - 20]), 16'h31);
		chk(16'(host.rx_q[n - 22]), 16'(CH_A));
		$display("host test done");
		boot(1'b1);
		chk(16'(sa), 16'h1);
		press(BTN_WHITE);
		chk({wi, ci}, 16'h2);
		press(BTN_COLOR);
		chk({wi, ci}, 16'h1);
		$display("standalone test done");
		summarize();
	end
	// Watchdog well beyond the expected run of about 48000 cycles
	initial begin
		repeat (80000) @(posedge i_ref_clk);
		n_fail++;
		summarize();
	end
endmodule : tb_rgb_led_pwm_lighting_control
